// File: src/sce_pkg.sv
// package for the serial control and enable slice
package sce_pkg;
    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] ADDR_FORMAT = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_TX_HOLD = 8'h0C;
    localparam logic [7:0] ADDR_RX_HOLD = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
    localparam logic [7:0] ADDR_MODE = 8'h1C;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CTRL_TX_IRQ_EN = 7;
    localparam int CTRL_RX_IRQ_EN = 6;
    localparam int CTRL_TX_ON = 5;
    localparam int CTRL_RX_ON = 4;
    localparam int CTRL_ADDR_WAKE = 3;
    localparam int FMT_PAR_EN = 5;
    localparam int FMT_PAR_ODD = 4;
    localparam int FMT_ADDR_MODE = 2;
    localparam int ST_TX_FREE = 7;
    localparam int ST_RX_FULL = 6;
    localparam int ST_OVERRUN = 5;
    localparam int ST_FRAMING = 4;
    localparam int ST_PARITY = 3;
    localparam int ST_ADDR_FLAG = 1;
    localparam int MODE_CARD = 0;
    localparam int MODE_ASYNC = 1;
    // ************************************************************
    // reset values and timing
    // ************************************************************
    localparam logic [7:0] FORMAT_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h80;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h7;
    localparam logic [1:0] MODE_RESET = 2'h2;
    localparam int PCLK_MHZ = 100;
    localparam logic [7:0] DIV_BY_8 = 8'h07;
    localparam logic [7:0] DIV_BY_32 = 8'h1F;
    localparam logic [7:0] DIV_BY_128 = 8'h7F;
    // received frame as handed over by the receive engine
    typedef struct packed {
        logic [7:0] data;
        logic addr_flag_bit;
        logic framing_bad;
        logic parity_bad;
    } sce_frame_type;
endpackage

// File: src/sce_ctrl.sv
// serial control and enable slice: format, control, status and interrupt logic
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module sce_ctrl
    import sce_pkg::*;
(
    input wire logic pclk, // peripheral clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic rx_start_pin, // start bit or serial clock seen on the line
    input wire logic frame_done, // receive engine finished a frame
    input wire sce_frame_type frame_in, // frame contents with that pulse
    input wire logic tx_taken, // transmit engine loaded tx_holding
    output logic tx_go, // transmit request to the engine
    output logic [7:0] tx_data, // byte for the engine
    output logic rx_run, // reception running
    output logic baud_tick, // prescaled baud generator clock enable
    output logic par_en_eff, // parity in use after mode override
    output logic par_odd_eff, // odd parity selected
    output logic tx_irq, // transmit request
    output logic rx_irq, // receive request
    output logic rx_err_irq, // receive error request
    output logic irq // combined level interrupt
);
    // ************************************************************
    // state
    // ************************************************************
    logic [7:0] fmt, next_fmt;
    logic [7:0] ctrl, next_ctrl;
    logic [7:0] stat, next_stat;
    logic [7:0] tx_hold, next_tx_hold;
    logic [7:0] rx_hold, next_rx_hold;
    logic [2:0] ev, next_ev;
    logic [2:0] mask, next_mask;
    logic [1:0] mode, next_mode;
    logic [7:0] stat_seen, next_stat_seen;
    logic [7:0] div_cnt, next_div_cnt;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic next_tx_go, next_rx_run, next_baud_tick;
    logic next_tx_irq, next_rx_irq, next_rx_err_irq, next_irq;
    logic [1:0] start_sync;
    logic start_seen;

    // prescaler terminal count; card mode only, plain pclk otherwise
    function automatic logic [7:0] div_limit(input logic [1:0] sel, input logic card);
        if (!card) begin
            return 8'h00;
        end
        unique case (sel)
            2'b00: return 8'h00;
            2'b01: return DIV_BY_8;
            2'b10: return DIV_BY_32;
            2'b11: return DIV_BY_128;
        endcase
    endfunction

    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic acc;
        logic wr;
        logic rd;
        logic mapped;
        logic mp_mode;
        logic skip;
        logic [7:0] wd;
        acc = psel && penable && pready;
        wr = acc && pwrite;
        rd = acc && !pwrite;
        wd = pwdata[7:0];
        mapped = paddr[1:0] == 2'b00 && paddr <= ADDR_MODE;
        mp_mode = fmt[FMT_ADDR_MODE] && mode[MODE_ASYNC];
        skip = mp_mode && ctrl[CTRL_ADDR_WAKE] && !frame_in.addr_flag_bit;
        next_fmt = fmt;
        next_ctrl = ctrl;
        next_stat = stat;
        next_tx_hold = tx_hold;
        next_rx_hold = rx_hold;
        next_ev = ev;
        next_mask = mask;
        next_mode = mode;
        next_stat_seen = stat_seen;
        next_prdata = 32'h0000_0000;
        next_pready = psel && !penable;
        next_pslverr = 1'b0;
        next_tx_go = tx_go;
        next_rx_run = ctrl[CTRL_RX_ON] && (rx_run || start_seen);
        if (psel && !penable) begin
            next_pslverr = !mapped;
            unique case (1'b1)
                is_addr(paddr, ADDR_FORMAT): next_prdata[7:0] = fmt;
                is_addr(paddr, ADDR_CTRL): next_prdata[7:0] = ctrl;
                is_addr(paddr, ADDR_STATUS): next_prdata[7:0] = stat;
                is_addr(paddr, ADDR_TX_HOLD): next_prdata[7:0] = tx_hold;
                is_addr(paddr, ADDR_RX_HOLD): next_prdata[7:0] = rx_hold;
                is_addr(paddr, ADDR_IRQ_STAT): next_prdata[2:0] = ev;
                is_addr(paddr, ADDR_IRQ_MASK): next_prdata[2:0] = mask;
                is_addr(paddr, ADDR_MODE): next_prdata[1:0] = mode;
                default: next_prdata = 32'h0000_0000;
            endcase
        end
        // reads and software writes first, hardware sets after so they win
        // remember only what software was shown; a flag set after the setup cycle stays armed
        if (rd && is_addr(paddr, ADDR_STATUS)) begin
            next_stat_seen = prdata[7:0];
        end
        // clear only the events that the read returned, so a late event is not lost
        if (rd && is_addr(paddr, ADDR_IRQ_STAT)) begin
            next_ev = ev & ~prdata[2:0];
        end
        if (wr) begin
            if (is_addr(paddr, ADDR_FORMAT)) next_fmt = wd;
            if (is_addr(paddr, ADDR_CTRL)) next_ctrl = wd;
            if (is_addr(paddr, ADDR_TX_HOLD)) next_tx_hold = wd;
            if (is_addr(paddr, ADDR_IRQ_MASK)) next_mask = wd[2:0];
            if (is_addr(paddr, ADDR_MODE)) next_mode = wd[1:0];
            if (is_addr(paddr, ADDR_STATUS)) begin
                // a flag clears only when written 0 after it was read as 1
                for (int b = 1; b < 8; b++) begin
                    if (!wd[b] && stat_seen[b]) begin
                        next_stat[b] = 1'b0;
                    end
                end
                next_stat_seen = 8'h00;
            end
        end
        if (!ctrl[CTRL_RX_ON]) begin
            next_rx_run = 1'b0;
        end
        // receive flags only change on a frame, never on rx_on
        if (frame_done && rx_run && !skip) begin
            if (stat[ST_RX_FULL]) begin
                next_stat[ST_OVERRUN] = 1'b1;
            end else begin
                next_rx_hold = frame_in.data;
                next_stat[ST_RX_FULL] = 1'b1;
                // error flags are sticky: only software clears them
                next_stat[ST_FRAMING] = next_stat[ST_FRAMING] | frame_in.framing_bad;
                next_stat[ST_PARITY] = next_stat[ST_PARITY]
                    | (frame_in.parity_bad && !mp_mode);
            end
            next_ev[1] = 1'b1;
            if (mp_mode && frame_in.addr_flag_bit) begin
                next_stat[ST_ADDR_FLAG] = 1'b1;
                next_ctrl[CTRL_ADDR_WAKE] = 1'b0;
            end
            if (frame_in.framing_bad || (frame_in.parity_bad && !mp_mode) || stat[ST_RX_FULL]) begin
                next_ev[2] = 1'b1;
            end
        end
        if (tx_taken && tx_go) begin
            next_tx_go = 1'b0;
            next_stat[ST_TX_FREE] = 1'b1;
            next_ev[0] = 1'b1;
        end
        if (ctrl[CTRL_TX_ON] && !stat[ST_TX_FREE] && !tx_go) begin
            next_tx_go = 1'b1;
        end
        if (!ctrl[CTRL_TX_ON]) begin
            next_tx_go = 1'b0;
            next_stat[ST_TX_FREE] = 1'b1;
        end
        next_stat[0] = 1'b0;
        next_stat[2] = 1'b0;
        next_tx_irq = ctrl[CTRL_TX_IRQ_EN] && stat[ST_TX_FREE];
        next_rx_irq = ctrl[CTRL_RX_IRQ_EN] && stat[ST_RX_FULL];
        next_rx_err_irq = ctrl[CTRL_RX_IRQ_EN]
            && (stat[ST_OVERRUN] || stat[ST_FRAMING] || stat[ST_PARITY]);
        next_irq = |(ev & mask);
        next_baud_tick = 1'b0;
        next_div_cnt = div_cnt + 8'h01;
        if (div_cnt >= div_limit(fmt[1:0], mode[MODE_CARD])) begin
            next_div_cnt = 8'h00;
            next_baud_tick = 1'b1;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_sync <= 2'b00;
            start_seen <= 1'b0;
        end else begin
            start_sync <= {start_sync[0], rx_start_pin};
            start_seen <= start_sync[1];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fmt <= FORMAT_RESET;
            ctrl <= CTRL_RESET;
            stat <= STATUS_RESET;
            tx_hold <= 8'h00;
            rx_hold <= 8'h00;
            ev <= 3'h0;
            mask <= IRQ_MASK_RESET;
            mode <= MODE_RESET;
            stat_seen <= 8'h00;
            div_cnt <= 8'h00;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            tx_go <= 1'b0;
            tx_data <= 8'h00;
            rx_run <= 1'b0;
            baud_tick <= 1'b0;
            par_en_eff <= 1'b0;
            par_odd_eff <= 1'b0;
            tx_irq <= 1'b0;
            rx_irq <= 1'b0;
            rx_err_irq <= 1'b0;
            irq <= 1'b0;
        end else begin
            fmt <= next_fmt;
            ctrl <= next_ctrl;
            stat <= next_stat;
            tx_hold <= next_tx_hold;
            rx_hold <= next_rx_hold;
            ev <= next_ev;
            mask <= next_mask;
            mode <= next_mode;
            stat_seen <= next_stat_seen;
            div_cnt <= next_div_cnt;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            tx_go <= next_tx_go;
            tx_data <= next_tx_hold;
            rx_run <= next_rx_run;
            baud_tick <= next_baud_tick;
            par_en_eff <= next_fmt[FMT_PAR_EN] && !next_fmt[FMT_ADDR_MODE];
            par_odd_eff <= next_fmt[FMT_PAR_ODD] && !next_fmt[FMT_ADDR_MODE];
            tx_irq <= next_tx_irq;
            rx_irq <= next_rx_irq;
            rx_err_irq <= next_rx_err_irq;
            irq <= next_irq;
        end
    end
endmodule // sce_ctrl

// File: verif/sce_ctrl_assertions.sv
// port checks for the serial control slice
`timescale 1ns/1ps
module sce_ctrl_assertions
    import sce_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic tx_go, // transmit request
    input wire logic tx_taken, // byte taken
    input wire logic rx_run, // reception running
    input wire logic baud_tick, // prescaler pulse
    input wire logic tx_irq, // transmit request irq
    input wire logic rx_irq, // receive irq
    input wire logic rx_err_irq // receive error irq
);
    logic wr;
    logic sh_card;
    logic [7:0] sh_ctl, sh_fmt, age, gap, lim;
    assign wr = psel && penable && pready && pwrite;
    assign lim = !sh_card ? 8'h00 : sh_fmt[1:0] == 2'h1 ? 8'h07 :
        sh_fmt[1:0] == 2'h2 ? 8'h1F : sh_fmt[1:0] == 2'h3 ? 8'h7F : 8'h00;
    // shadows only bits 7:4 are trusted; bit 3 may clear itself
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {sh_card, sh_ctl, sh_fmt, age, gap} <= '0;
        end else begin
            if (wr && paddr == ADDR_CTRL) sh_ctl <= pwdata[7:0];
            if (wr && paddr == ADDR_FORMAT) sh_fmt <= pwdata[7:0];
            if (wr && paddr == ADDR_MODE) sh_card <= pwdata[0];
            age <= (wr && (paddr == ADDR_FORMAT || paddr == ADDR_MODE)) ? 8'h00 :
                (age == 8'hFF ? age : age + 8'h01);
            gap <= baud_tick ? 8'h00 : (gap == 8'hFF ? gap : gap + 8'h01);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable ##1 psel && penable;
    endsequence
    a_ready_access: assert property (s_setup |-> pready) else $error("late ready");
    a_ready_bus: assert property (pready |-> psel && penable) else $error("stray ready");
    a_err_map: assert property (pready |-> pslverr == (paddr > 8'h1C || paddr[1:0] != 2'h0))
        else $error("bad slave error");
    a_tx_irq_mask: assert property (!sh_ctl[7] [*3] |-> !tx_irq) else $error("tx irq");
    a_rx_irq_mask: assert property (!sh_ctl[6] [*3] |-> !rx_irq && !rx_err_irq)
        else $error("rx irq");
    a_tx_go_off: assert property (!sh_ctl[5] [*3] |-> !tx_go) else $error("tx off");
    a_rx_run_off: assert property (!sh_ctl[4] [*3] |-> !rx_run) else $error("rx off");
    a_tx_go_hold: assert property (tx_go && !tx_taken && sh_ctl[5] |=> tx_go)
        else $error("tx dropped");
    a_baud_gap: assert property (baud_tick && age > 8'h8C |-> gap == lim)
        else $error("baud period");
    a_baud_due: assert property (age > 8'h8C |-> gap <= lim) else $error("baud late");
endmodule // sce_ctrl_assertions

// File: verif/sce_peer.sv
// serial peer: takes transmit bytes and hands in received frames
`timescale 1ns/1ps
module sce_peer
    import sce_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic tx_go, // transmit request
    input wire logic [3:0] lag, // cycles before a byte is taken
    output logic tx_taken, // byte taken
    output logic frame_done, // frame finished
    output sce_frame_type frame_in, // frame contents
    output logic rx_start_pin // line activity
);
    initial begin
        {tx_taken, frame_done, rx_start_pin} = 3'h0;
        frame_in = '0;
    end
    always begin
        @(posedge pclk iff tx_go);
        repeat (lag) @(posedge pclk);
        tx_taken <= 1'b1;
        @(posedge pclk);
        tx_taken <= 1'b0;
    end
    task automatic send(input logic [7:0] d, input logic flag, input logic bad);
        @(posedge pclk);
        rx_start_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        rx_start_pin <= 1'b0;
        repeat (4) @(posedge pclk);
        frame_done <= 1'b1;
        frame_in <= '{d, flag, bad, bad};
        @(posedge pclk);
        frame_done <= 1'b0;
        // stale contents must not look valid after the pulse
        frame_in <= ~frame_in;
    endtask
endmodule // sce_peer

// File: verif/test_sce_ctrl.sv
// self-checking bench for the serial control slice
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module test_sce_ctrl
    import sce_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pslverr, pready, err;
    logic [7:0] paddr, tx_data, seed, b, v;
    logic [31:0] pwdata, prdata;
    logic rx_start_pin, frame_done, tx_taken, tx_go, rx_run, baud_tick;
    logic par_en_eff, par_odd_eff, tx_irq, rx_irq, rx_err_irq, irq;
    logic [3:0] lag;
    sce_frame_type frame_in;
    int n_mismatch, comparisons, k, cnt;
    logic [7:0] exp_q[$];
    logic [7:0] rst_v[8] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h07, 8'h02};
    sce_ctrl uut (.*);
    sce_peer peer (.*);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, 24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        // no limit here: the watchdog ends a hung transfer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        v = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        `CHK(v, e)
    endtask
    // outputs are registered one or two cycles behind the state that drives them
    task automatic settle;
        repeat (3) @(posedge pclk);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {presetn, lag, seed} = {1'b0, 4'h0, 8'h29};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (k = 0; k < 8; k++) if (k != 3) rd(8'(k * 4), rst_v[k]);
        apb(1'b1, 8'h22, 8'hFF);
        `CHK(err, 1'b1)
        for (k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            b = seed & 8'h37;
            apb(1'b1, ADDR_FORMAT, b);
            rd(ADDR_FORMAT, b);
            repeat (2) @(posedge pclk);
            `CHK({par_en_eff, par_odd_eff}, {b[5], b[4]} & {2{~b[2]}})
        end
        apb(1'b1, ADDR_MODE, 8'h01);
        for (k = 0; k < 4; k++) begin
            apb(1'b1, ADDR_FORMAT, 8'(k));
            repeat (150) @(posedge pclk);
            cnt = 0;
            repeat (256) begin @(posedge pclk); cnt += (baud_tick === 1'b1); end
            `CHK(cnt, 256 >> (k == 0 ? 0 : 2 * k + 1))
        end
        apb(1'b1, ADDR_MODE, 8'h02);
        apb(1'b1, ADDR_FORMAT, 8'h00);
        apb(1'b1, ADDR_STATUS, 8'h00);
        rd(ADDR_STATUS, 8'h80);
        apb(1'b1, ADDR_CTRL, 8'hA0);
        settle();
        `CHK(tx_irq, 1'b1)
        for (k = 0; k < 2; k++) begin
            lag <= k ? 4'hC : 4'h0;
            seed = lfsr(seed);
            apb(1'b1, ADDR_TX_HOLD, seed);
            rd(ADDR_STATUS, 8'h80);
            apb(1'b1, ADDR_STATUS, 8'h00);
            if (k) begin
                settle();
                `CHK(tx_irq, 1'b0)
            end
            while (tx_taken !== 1'b1) @(posedge pclk);
            `CHK(tx_data, seed)
            settle();
            `CHK(tx_irq, 1'b1)
        end
        `CHK(irq, 1'b1)
        rd(ADDR_IRQ_STAT, 8'h01);
        rd(ADDR_IRQ_STAT, 8'h00);
        apb(1'b1, ADDR_CTRL, 8'h20);
        settle();
        `CHK(tx_irq, 1'b0)
        apb(1'b1, ADDR_IRQ_MASK, 8'h05);
        apb(1'b1, ADDR_CTRL, 8'h50);
        seed = lfsr(seed);
        exp_q.push_back(seed);
        peer.send(seed, 1'b0, 1'b0);
        settle();
        `CHK(rx_run, 1'b1)
        `CHK({rx_irq, irq}, 2'h2)
        apb(1'b1, ADDR_IRQ_MASK, 8'h07);
        settle();
        `CHK(irq, 1'b1)
        rd(ADDR_IRQ_STAT, 8'h02);
        rd(ADDR_STATUS, 8'hC0);
        rd(ADDR_RX_HOLD, exp_q.pop_front());
        apb(1'b1, ADDR_STATUS, 8'h80);
        settle();
        `CHK(rx_irq, 1'b0)
        peer.send(lfsr(seed), 1'b0, 1'b1);
        settle();
        `CHK(rx_err_irq, 1'b1)
        apb(1'b1, ADDR_CTRL, 8'h40);
        apb(1'b0, ADDR_STATUS, 8'h00);
        `CHK(v & 8'h38, 8'h18)
        settle();
        `CHK(rx_err_irq, 1'b1)
        apb(1'b1, ADDR_CTRL, 8'h00);
        settle();
        `CHK(rx_err_irq, 1'b0)
        apb(1'b1, ADDR_STATUS, 8'h80);
        apb(1'b0, ADDR_IRQ_STAT, 8'h00);
        apb(1'b1, ADDR_FORMAT, 8'h04);
        apb(1'b1, ADDR_CTRL, 8'h58);
        peer.send(seed, 1'b0, 1'b1);
        settle();
        `CHK({rx_irq, rx_err_irq}, 2'h0)
        rd(ADDR_STATUS, 8'h80);
        seed = lfsr(seed);
        peer.send(seed, 1'b1, 1'b0);
        settle();
        `CHK(rx_irq, 1'b1)
        rd(ADDR_CTRL, 8'h50);
        rd(ADDR_STATUS, 8'hC2);
        rd(ADDR_RX_HOLD, seed);
        end_of_test();
    end
endmodule // test_sce_ctrl
bind sce_ctrl sce_ctrl_assertions chk (.*);
